// File: logic/tcsf_map.svh
// register map, field positions, reset values and timing counts of the fault/control bank
`ifndef TCSF_MAP_SVH
`define TCSF_MAP_SVH

`define TCSF_ADDR_FAULT_CHG   8'h12
`define TCSF_ADDR_FAULT_STATE 8'h13
`define TCSF_ADDR_CAP_CTRL    8'h18
`define TCSF_ADDR_ILIM        8'h1e
`define TCSF_ADDR_WATCH       8'h20
`define TCSF_ADDR_WINDOW      8'h22
`define TCSF_ADDR_SOFT_RST    8'h23

`define TCSF_CHG_THERMAL      7
`define TCSF_CHG_PU_OVP       5
`define TCSF_CHG_PU_OK        4
`define TCSF_CHG_REVERSE      2
`define TCSF_CHG_OVERCUR      1
`define TCSF_CHG_OVERVOLT     0

`define TCSF_ST_PU_OVP        7
`define TCSF_ST_PU_OK         6
`define TCSF_ST_REV1          5
`define TCSF_ST_REV2          4
`define TCSF_ST_OCP1          3
`define TCSF_ST_OCP2          2
`define TCSF_ST_OVP1          1
`define TCSF_ST_OVP2          0

`define TCSF_CAP_DISCH        4
`define TCSF_CAP_SUPPLY       0
`define TCSF_CAP_RSVD_ONES    8'h20
`define TCSF_WATCH_EN         7
`define TCSF_WATCH_LOW_THR    6
`define TCSF_WATCH_RSVD_ONES  8'h20

`define TCSF_RST_DISCH        1'b0
`define TCSF_RST_SUPPLY       1'b1
`define TCSF_RST_ILIM         4'h0
`define TCSF_RST_WATCH_EN     1'b1
`define TCSF_RST_LOW_THR      1'b0
`define TCSF_RST_SHIFT        4'h0

`define TCSF_NOMINAL_MV       13'd5000
`define TCSF_MV_PER_PCT       13'd50
`define TCSF_WINDOW_PCT       13'd5
`define TCSF_HUNDRED_PCT      13'd100

`define TCSF_CLK_MHZ          50
`define TCSF_DISCH_TIME_MS    250
`define TCSF_DISCH_CYCLES     (`TCSF_DISCH_TIME_MS * 1000 * `TCSF_CLK_MHZ)

`endif

// File: logic/tcsf_pkg.sv
// types shared by the fault/control register bank
package tcsf_pkg;
    typedef enum logic [0:0] {
        TCSF_DISCH_IDLE   = 1'b0,
        TCSF_DISCH_ACTIVE = 1'b1
    } tcsf_disch_state_t;

    typedef logic [7:0]  tcsf_byte_t;
    typedef logic [12:0] tcsf_mv_t;
endpackage : tcsf_pkg

// File: logic/tcsf_regs.sv
// fault transition/status flags and cable power / bus window control registers
`timescale 1ns/1ps
`include "tcsf_map.svh"
module tcsf_regs #(
    parameter int unsigned DISCH_CYCLES = `TCSF_DISCH_CYCLES
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RESETN,
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic              i_reg_wr,
    input  wire tcsf_pkg::tcsf_byte_t i_reg_wdata,
    input  wire logic              i_reg_rd,
    output tcsf_pkg::tcsf_byte_t   o_reg_rdata,
    input  wire tcsf_pkg::tcsf_byte_t i_fault_status,
    input  wire logic              i_over_temp,
    input  wire logic [1:0]        i_advertised_current_code,
    input  wire logic              i_attached,
    input  wire logic              i_cable_power_above_uvlo,
    input  wire logic              i_nvm_discharge_on,
    input  wire logic              i_nvm_supply_on,
    input  wire logic [3:0]        i_nvm_current_limit,
    input  wire logic [3:0]        i_nvm_upper_shift,
    input  wire logic [3:0]        i_nvm_lower_shift,
    output logic                   o_cable_power_supply_on,
    output logic                   o_cable_power_discharge,
    output logic [3:0]             o_cable_power_current_limit,
    output logic                   o_cable_power_watch_on,
    output logic                   o_cable_power_low_threshold_sel,
    output logic                   o_cable_power_path_on,
    output logic                   o_cable_power_present,
    output tcsf_pkg::tcsf_mv_t     o_bus_upper_limit_mv,
    output tcsf_pkg::tcsf_mv_t     o_bus_lower_limit_mv,
    output logic                   o_soft_reset_hold
);
    import tcsf_pkg::*;

    logic              rst_meta_q;
    logic              rst_sync_q;
    logic              core_rst_n;
    tcsf_byte_t        status_q;
    tcsf_byte_t        chg_q;
    tcsf_byte_t        chg_set;
    tcsf_byte_t        status_diff;
    logic              nvm_load_q;
    logic              disch_on_q;
    logic              supply_on_q;
    logic [3:0]        ilim_q;
    logic              watch_on_q;
    logic              low_thr_q;
    logic [3:0]        upper_shift_q;
    logic [3:0]        lower_shift_q;
    logic              soft_rst_q;
    logic              attached_q;
    tcsf_disch_state_t disch_state_q;
    logic [31:0]       disch_cnt_q;
    tcsf_byte_t        rdata_d;
    tcsf_byte_t        rdata_q;
    tcsf_mv_t          upper_mv_q;
    tcsf_mv_t          lower_mv_q;
    logic              wr_cap;
    logic              wr_ilim;
    logic              wr_watch;
    logic              wr_window;
    logic              wr_soft;
    logic              rd_chg;

    // pin reset released through two flops
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // soft reset resets device state but never the control registers
    assign core_rst_n = rst_sync_q & ~soft_rst_q;

    assign wr_cap    = i_reg_wr && (i_reg_addr == `TCSF_ADDR_CAP_CTRL);
    assign wr_ilim   = i_reg_wr && (i_reg_addr == `TCSF_ADDR_ILIM);
    assign wr_watch  = i_reg_wr && (i_reg_addr == `TCSF_ADDR_WATCH);
    assign wr_window = i_reg_wr && (i_reg_addr == `TCSF_ADDR_WINDOW);
    assign wr_soft   = i_reg_wr && (i_reg_addr == `TCSF_ADDR_SOFT_RST);
    assign rd_chg    = i_reg_rd && (i_reg_addr == `TCSF_ADDR_FAULT_CHG);

    // fault condition snapshot; all bits zero out of reset
    always_ff @(posedge I_CLK or negedge core_rst_n) begin
        if (!core_rst_n) begin
            status_q <= 8'h00;
        end else begin
            status_q <= i_fault_status;
        end
    end

    assign status_diff = status_q ^ i_fault_status;

    always_comb begin
        chg_set = 8'h00;
        chg_set[`TCSF_CHG_THERMAL]  = i_over_temp;
        chg_set[`TCSF_CHG_PU_OVP]   = status_diff[`TCSF_ST_PU_OVP];
        chg_set[`TCSF_CHG_PU_OK]    = status_diff[`TCSF_ST_PU_OK];
        chg_set[`TCSF_CHG_REVERSE]  = status_diff[`TCSF_ST_REV1]
                                    | status_diff[`TCSF_ST_REV2];
        chg_set[`TCSF_CHG_OVERCUR]  = status_diff[`TCSF_ST_OCP1]
                                    | status_diff[`TCSF_ST_OCP2];
        chg_set[`TCSF_CHG_OVERVOLT] = status_diff[`TCSF_ST_OVP1]
                                    | status_diff[`TCSF_ST_OVP2];
    end

    // read clears, but a change seen in the same cycle survives
    always_ff @(posedge I_CLK or negedge core_rst_n) begin
        if (!core_rst_n) begin
            chg_q <= 8'h00;
        end else begin
            chg_q <= (rd_chg ? 8'h00 : chg_q) | chg_set;
        end
    end

    // nonvolatile defaults cannot enter under async reset, so one cycle after release copies them
    always_ff @(posedge I_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            nvm_load_q <= 1'b1;
        end else begin
            nvm_load_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            disch_on_q  <= `TCSF_RST_DISCH;
            supply_on_q <= `TCSF_RST_SUPPLY;
        end else if (nvm_load_q) begin
            disch_on_q  <= i_nvm_discharge_on;
            supply_on_q <= i_nvm_supply_on;
        end else if (wr_cap) begin
            disch_on_q  <= i_reg_wdata[`TCSF_CAP_DISCH];
            supply_on_q <= i_reg_wdata[`TCSF_CAP_SUPPLY];
        end
    end

    always_ff @(posedge I_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ilim_q <= `TCSF_RST_ILIM;
        end else if (nvm_load_q) begin
            ilim_q <= i_nvm_current_limit;
        end else if (wr_ilim) begin
            ilim_q <= i_reg_wdata[3:0];
        end
    end

    always_ff @(posedge I_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            watch_on_q <= `TCSF_RST_WATCH_EN;
            low_thr_q  <= `TCSF_RST_LOW_THR;
        end else if (wr_watch) begin
            watch_on_q <= i_reg_wdata[`TCSF_WATCH_EN];
            low_thr_q  <= i_reg_wdata[`TCSF_WATCH_LOW_THR];
        end
    end

    always_ff @(posedge I_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            soft_rst_q <= 1'b0;
        end else if (wr_soft) begin
            soft_rst_q <= i_reg_wdata[0];
        end
    end

    // pin reset only: a soft reset must not fake an attach and reload the shifts
    always_ff @(posedge I_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            attached_q <= 1'b0;
        end else begin
            attached_q <= i_attached;
        end
    end

    // window shift: reset values while unattached, defaults loaded at attach
    always_ff @(posedge I_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            upper_shift_q <= `TCSF_RST_SHIFT;
            lower_shift_q <= `TCSF_RST_SHIFT;
        end else if (!i_attached) begin
            upper_shift_q <= `TCSF_RST_SHIFT;
            lower_shift_q <= `TCSF_RST_SHIFT;
        end else if (!attached_q) begin
            upper_shift_q <= i_nvm_upper_shift;
            lower_shift_q <= i_nvm_lower_shift;
        end else if (wr_window) begin
            upper_shift_q <= i_reg_wdata[7:4];
            lower_shift_q <= i_reg_wdata[3:0];
        end
    end

    // limits in mV: nominal/100 per percent, window 5 % each side, then shifted
    always_ff @(posedge I_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            upper_mv_q <= 13'h0000;
            lower_mv_q <= 13'h0000;
        end else begin
            upper_mv_q <= 13'(`TCSF_MV_PER_PCT * (`TCSF_HUNDRED_PCT + `TCSF_WINDOW_PCT
                          + 13'(upper_shift_q)));
            lower_mv_q <= 13'(`TCSF_MV_PER_PCT * (`TCSF_HUNDRED_PCT - `TCSF_WINDOW_PCT
                          - 13'(lower_shift_q)));
        end
    end

    // discharge runs a fixed time after detach; clearing the enable cuts it short
    always_ff @(posedge I_CLK or negedge core_rst_n) begin
        if (!core_rst_n) begin
            disch_state_q <= TCSF_DISCH_IDLE;
            disch_cnt_q   <= 32'h0000_0000;
        end else begin
            case (disch_state_q)
                TCSF_DISCH_IDLE: begin
                    if (attached_q && !i_attached && disch_on_q) begin
                        disch_state_q <= TCSF_DISCH_ACTIVE;
                        disch_cnt_q   <= 32'(DISCH_CYCLES - 1);
                    end
                end
                TCSF_DISCH_ACTIVE: begin
                    if (!disch_on_q || disch_cnt_q == 32'h0000_0000) begin
                        disch_state_q <= TCSF_DISCH_IDLE;
                    end else begin
                        disch_cnt_q <= disch_cnt_q - 32'h0000_0001;
                    end
                end
                default: begin
                    disch_state_q <= TCSF_DISCH_IDLE;
                end
            endcase
        end
    end

    // read mux; reserved bits show their reset values
    always_comb begin
        rdata_d = 8'h00;
        case (i_reg_addr)
            `TCSF_ADDR_FAULT_CHG:   rdata_d = chg_q;
            `TCSF_ADDR_FAULT_STATE: rdata_d = status_q;
            `TCSF_ADDR_CAP_CTRL: begin
                rdata_d = `TCSF_CAP_RSVD_ONES;
                rdata_d[7:6] = i_advertised_current_code;
                rdata_d[`TCSF_CAP_DISCH]  = disch_on_q;
                rdata_d[`TCSF_CAP_SUPPLY] = supply_on_q;
            end
            `TCSF_ADDR_ILIM:        rdata_d = {4'h0, ilim_q};
            `TCSF_ADDR_WATCH: begin
                rdata_d = `TCSF_WATCH_RSVD_ONES;
                rdata_d[`TCSF_WATCH_EN]      = watch_on_q;
                rdata_d[`TCSF_WATCH_LOW_THR] = low_thr_q;
            end
            `TCSF_ADDR_WINDOW:      rdata_d = {upper_shift_q, lower_shift_q};
            `TCSF_ADDR_SOFT_RST:    rdata_d = {7'h00, soft_rst_q};
            default:                rdata_d = 8'h00;
        endcase
    end

    // data must keep answering while soft reset is held, so it uses the pin reset
    always_ff @(posedge I_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q <= 8'h00;
        end else if (i_reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign o_reg_rdata                     = rdata_q;
    assign o_cable_power_supply_on         = supply_on_q;
    assign o_cable_power_discharge         = (disch_state_q == TCSF_DISCH_ACTIVE);
    assign o_cable_power_current_limit     = ilim_q;
    assign o_cable_power_watch_on          = watch_on_q;
    assign o_cable_power_low_threshold_sel = low_thr_q;
    assign o_cable_power_path_on           = supply_on_q & watch_on_q & core_rst_n;
    assign o_cable_power_present           = i_cable_power_above_uvlo & watch_on_q;
    assign o_bus_upper_limit_mv            = upper_mv_q;
    assign o_bus_lower_limit_mv            = lower_mv_q;
    assign o_soft_reset_hold               = soft_rst_q;
endmodule : tcsf_regs

// File: verification/tcsf_host.sv
// host model driving the byte register port, one strobe per access
`timescale 1ns/1ps
module tcsf_host (
    input  wire logic                 I_CLK,
    output logic [7:0]                o_addr,
    output logic                      o_wr,
    output tcsf_pkg::tcsf_byte_t      o_wdata,
    output logic                      o_rd,
    input  wire tcsf_pkg::tcsf_byte_t i_rdata
);
    import tcsf_pkg::*;
    initial begin
        o_addr  = 8'h00;
        o_wr    = 1'b0;
        o_wdata = 8'h00;
        o_rd    = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input tcsf_byte_t d);
        @(posedge I_CLK);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge I_CLK);
        o_wr    <= 1'b0;
        // idle bus shows the inverse, so a stale value is never mistaken for a live one
        o_addr  <= ~a;
        o_wdata <= ~d;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output tcsf_byte_t d);
        @(posedge I_CLK);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge I_CLK);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask : rd_reg
endmodule : tcsf_host

// File: verification/tcsf_props.sv
// concurrent checks on the port behaviour of the fault/control register bank
`timescale 1ns/1ps
module tcsf_props (
    input wire logic                 I_CLK,
    input wire logic                 I_RESETN,
    input wire logic [7:0]           i_reg_addr,
    input wire logic                 i_reg_wr,
    input wire tcsf_pkg::tcsf_byte_t i_reg_wdata,
    input wire logic                 i_reg_rd,
    input wire tcsf_pkg::tcsf_byte_t o_reg_rdata,
    input wire tcsf_pkg::tcsf_byte_t i_fault_status,
    input wire logic                 i_over_temp,
    input wire logic [1:0]           i_advertised_current_code,
    input wire logic                 i_attached,
    input wire logic                 o_cable_power_supply_on,
    input wire logic [3:0]           o_cable_power_current_limit,
    input wire logic                 o_cable_power_watch_on,
    input wire logic                 o_cable_power_path_on,
    input wire logic                 o_cable_power_present,
    input wire tcsf_pkg::tcsf_mv_t   o_bus_upper_limit_mv,
    input wire tcsf_pkg::tcsf_mv_t   o_bus_lower_limit_mv,
    input wire logic                 o_soft_reset_hold
);
    import tcsf_pkg::*;
    // edges since any reset; snapshots and nvm loads need a few edges to settle
    logic [2:0] rdy_q;
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdy_q <= 3'h0;
        end else if (o_soft_reset_hold) begin
            rdy_q <= 3'h0;
        end else if (rdy_q != 3'h7) begin
            rdy_q <= rdy_q + 3'h1;
        end
    end
    wire logic rdy = (rdy_q == 3'h7);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    sequence s_rd(logic [7:0] a); i_reg_rd && i_reg_addr == a; endsequence
    sequence s_wr(logic [7:0] a); rdy && i_reg_wr && i_reg_addr == a; endsequence
    sequence s_quiet; rdy && $stable(i_fault_status) && !i_over_temp; endsequence
    a_flags_clear: assert property (
        s_rd(8'h12) ##0 s_quiet ##1 s_quiet ##1 s_rd(8'h12) |=> o_reg_rdata == 8'h00)
        else $error("flags not cleared");
    a_pullup_change: assert property (
        (rdy && $changed(i_fault_status[7])) ##1 s_rd(8'h12) |=> o_reg_rdata[5])
        else $error("pull-up change lost");
    a_reverse_change: assert property (
        (rdy && $changed(i_fault_status[5:4])) ##1 s_rd(8'h12) |=> o_reg_rdata[2])
        else $error("reverse change lost");
    a_thermal_flag: assert property (
        (rdy && i_over_temp) ##1 s_rd(8'h12) |=> o_reg_rdata[7])
        else $error("thermal flag lost");
    a_flags_reserved: assert property (
        s_rd(8'h12) |=> !o_reg_rdata[6] && !o_reg_rdata[3])
        else $error("reserved flag set");
    a_status_view: assert property (
        s_rd(8'h13) ##0 s_quiet |=> o_reg_rdata == $past(i_fault_status))
        else $error("status view wrong");
    a_cap_layout: assert property (
        s_rd(8'h18) ##0 $stable(i_advertised_current_code)
        |=> o_reg_rdata[7:5] == {$past(i_advertised_current_code), 1'b1}
        && o_reg_rdata[3:0] == {3'h0, $past(o_cable_power_supply_on)})
        else $error("capability layout wrong");
    a_ilim_write: assert property (
        s_wr(8'h1e) |=> o_cable_power_current_limit == $past(i_reg_wdata[3:0]))
        else $error("limit not set");
    a_watch_write: assert property (
        s_wr(8'h20) |=> o_cable_power_watch_on == $past(i_reg_wdata[7]))
        else $error("watch not set");
    a_soft_write: assert property (
        s_wr(8'h23) |=> o_soft_reset_hold == $past(i_reg_wdata[0]))
        else $error("soft reset not set");
    a_watch_gates: assert property (
        !o_cable_power_watch_on |-> !o_cable_power_present && !o_cable_power_path_on)
        else $error("watch gate open");
    a_supply_gates: assert property (
        !o_cable_power_supply_on |-> !o_cable_power_path_on)
        else $error("path without supply");
    a_window_idle: assert property (
        (rdy && !i_attached)[*3]
        |=> o_bus_upper_limit_mv == 13'd5250 && o_bus_lower_limit_mv == 13'd4750)
        else $error("idle window wrong");
endmodule : tcsf_props
bind tcsf_regs tcsf_props u_props (
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_fault_status(i_fault_status), .i_over_temp(i_over_temp),
    .i_advertised_current_code(i_advertised_current_code), .i_attached(i_attached),
    .o_cable_power_supply_on(o_cable_power_supply_on),
    .o_cable_power_current_limit(o_cable_power_current_limit),
    .o_cable_power_watch_on(o_cable_power_watch_on),
    .o_cable_power_path_on(o_cable_power_path_on),
    .o_cable_power_present(o_cable_power_present),
    .o_bus_upper_limit_mv(o_bus_upper_limit_mv), .o_bus_lower_limit_mv(o_bus_lower_limit_mv),
    .o_soft_reset_hold(o_soft_reset_hold));

// File: verification/typec_source_fault_control_regs_tb_top.sv
// self-checking bench for the fault/control register bank
`timescale 1ns/1ps
module typec_source_fault_control_regs_tb_top;
    import tcsf_pkg::*;
    localparam int unsigned DISCH = 20;
    logic       I_CLK, I_RESETN, ot, att, uv, nd, ns, wr, rd;
    logic       sup, dis, won, thr, path, pres, hold;
    logic [1:0] cc;
    logic [3:0] nl, nu, nlo, ilim;
    logic [7:0] addr;
    tcsf_byte_t fs, rdata, wdata, rv, w, d;
    tcsf_mv_t   up, lo;
    int         failures, compares, cyc, n;
    tcsf_regs #(.DISCH_CYCLES(DISCH)) dut (
        .I_CLK(I_CLK), .I_RESETN(I_RESETN), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_fault_status(fs),
        .i_over_temp(ot), .i_advertised_current_code(cc), .i_attached(att),
        .i_cable_power_above_uvlo(uv), .i_nvm_discharge_on(nd), .i_nvm_supply_on(ns),
        .i_nvm_current_limit(nl), .i_nvm_upper_shift(nu), .i_nvm_lower_shift(nlo),
        .o_cable_power_supply_on(sup), .o_cable_power_discharge(dis),
        .o_cable_power_current_limit(ilim), .o_cable_power_watch_on(won),
        .o_cable_power_low_threshold_sel(thr), .o_cable_power_path_on(path),
        .o_cable_power_present(pres), .o_bus_upper_limit_mv(up),
        .o_bus_lower_limit_mv(lo), .o_soft_reset_hold(hold));
    tcsf_host u_host (.I_CLK(I_CLK), .o_addr(addr), .o_wr(wr), .o_wdata(wdata),
        .o_rd(rd), .i_rdata(rdata));
    initial begin
        I_CLK = 1'b0;
        forever #10 I_CLK = ~I_CLK;
    end
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    // a hang counts as a mismatch
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            test_done();
        end
    end
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        u_host.rd_reg(a, rv);
        chk({5'h0, rv}, {5'h0, e});
    endtask : rc
    task automatic hw_reset();
        @(posedge I_CLK);
        I_RESETN <= 1'b0;
        repeat (16) @(posedge I_CLK);
        I_RESETN <= 1'b1;
        repeat (4) @(posedge I_CLK);
    endtask : hw_reset
    // expected change flags from the xor of old and new status
    function automatic logic [7:0] chg(input logic [7:0] x);
        return {2'h0, x[7], x[6], 1'b0, |x[5:4], |x[3:2], |x[1:0]};
    endfunction : chg
    initial begin
        n = $urandom(32'h6c50);
        I_RESETN = 1'b0;
        fs = 8'h00;
        ot = 1'b0;
        att = 1'b0;
        uv = 1'b1;
        cc = 2'h1;
        nd = 1'(($urandom));
        ns = 1'(($urandom));
        nl = 4'(($urandom));
        nu = 4'(($urandom));
        nlo = 4'(($urandom));
        hw_reset();
        rc(8'h18, {cc, 1'b1, nd, 3'h0, ns});
        rc(8'h1e, {4'h0, nl});
        rc(8'h20, 8'ha0);
        rc(8'h22, 8'h00);
        rc(8'h12, 8'h00);
        u_host.wr_reg(8'h15, 8'hff);
        rc(8'h15, 8'h00);
        for (int i = 0; i < 6; i++) begin
            w = {i[0], 7'(($urandom))};
            @(posedge I_CLK);
            cc <= 2'(i % 3);
            uv <= w[1];
            u_host.wr_reg(8'h18, w);
            rc(8'h18, {2'(i % 3), 1'b1, w[4], 3'h0, w[0]});
            u_host.wr_reg(8'h20, w);
            rc(8'h20, {w[7:6], 2'h2, 4'h0});
            chk({12'h0, pres}, {12'h0, w[1] & w[7]});
            chk({12'h0, path}, {12'h0, w[0] & w[7]});
            chk({11'h0, won, thr}, {11'h0, w[7:6]});
        end
        for (int k = 0; k < 16; k++) begin
            u_host.wr_reg(8'h1e, 8'(k) | 8'hf0);
            chk({9'h0, ilim}, 13'(k));
        end
        for (int i = 0; i < 12; i++) begin
            w = (i < 8) ? 8'h01 << i : 8'(($urandom));
            d = fs ^ w;
            @(posedge I_CLK);
            fs <= w;
            rc(8'h12, chg(d));
            rc(8'h12, 8'h00);
            rc(8'h13, w);
        end
        u_host.wr_reg(8'h13, ~fs);
        rc(8'h13, fs);
        @(posedge I_CLK);
        ot <= 1'b1;
        rc(8'h12, 8'h80);
        @(posedge I_CLK);
        ot <= 1'b0;
        rc(8'h12, 8'h80);
        rc(8'h12, 8'h00);
        @(posedge I_CLK);
        att <= 1'b1;
        repeat (3) @(posedge I_CLK);
        #1;
        chk(up, 13'd50 * (13'd105 + 13'(nu)));
        chk(lo, 13'd50 * (13'd95 - 13'(nlo)));
        rc(8'h22, {nu, nlo});
        u_host.wr_reg(8'h22, 8'hf1);
        repeat (2) @(posedge I_CLK);
        #1;
        chk(up, 13'd6000);
        chk(lo, 13'd4700);
        u_host.wr_reg(8'h18, 8'h11);
        @(posedge I_CLK);
        att <= 1'b0;
        n = 0;
        repeat (DISCH + 8) begin
            @(posedge I_CLK);
            #1 n += (dis === 1'b1) ? 1 : 0;
        end
        chk(13'(n), 13'(DISCH));
        chk(up, 13'd5250);
        u_host.wr_reg(8'h22, 8'h33);
        rc(8'h22, 8'h00);
        u_host.wr_reg(8'h1e, 8'h05);
        u_host.wr_reg(8'h23, 8'h01);
        chk({12'h0, hold}, 13'h1);
        @(posedge I_CLK);
        fs <= ~fs;
        rc(8'h12, 8'h00);
        rc(8'h1e, 8'h05);
        u_host.wr_reg(8'h23, 8'h00);
        rc(8'h1e, 8'h05);
        hw_reset();
        rc(8'h1e, {4'h0, nl});
        rc(8'h23, 8'h00);
        test_done();
    end
endmodule : typec_source_fault_control_regs_tb_top
